/* File: hw/rop_pkg.sv */
package rop_pkg;

    // Register byte offsets
    localparam logic [7:0] CAUSE_OFS    = 8'h00;
    localparam logic [7:0] FEED_OFS     = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
    localparam logic [7:0] PIN_MUX_OFS  = 8'h10;

    // Reset cause register fields
    localparam int         ENABLE_BIT   = 7;
    localparam int         WD_FLAG_BIT  = 2;
    localparam int         CMD_FLAG_BIT = 1;
    localparam int         EXT_FLAG_BIT = 0;
    localparam logic [2:0] CAUSE_EXT    = 3'h1;
    localparam logic [2:0] CAUSE_CMD    = 3'h2;
    localparam logic [2:0] CAUSE_WD     = 3'h4;
    localparam logic       ENABLE_RST   = 1'b0;

    // Pin mux register: bit 0 selects the reset indicator function
    localparam int         PIN_MUX_BIT  = 0;
    localparam logic       PIN_MUX_RST  = 1'b0;

    // Interrupt status and mask layout
    localparam int         IRQ_W        = 3;
    localparam int         IRQ_WD_BIT   = 0;
    localparam int         IRQ_CMD_BIT  = 1;
    localparam int         IRQ_DONE_BIT = 2;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // Watchdog feed key
    localparam logic [7:0] FEED_KEY     = 8'h5a;

    // Timing
    localparam int         PULSE_CLOCKS        = 256;
    localparam logic [7:0] PULSE_LAST          = 8'(PULSE_CLOCKS - 1);
    localparam int         POWERUP_MAX_CLOCKS  = 258;
    localparam int         WDOG_TIMEOUT_CLOCKS = 65536;

    typedef enum logic [1:0] {
        ROP_IDLE  = 2'b01,
        ROP_PULSE = 2'b10
    } rop_state_t;

    function automatic logic rop_hit(input logic [7:0] addr, input logic [7:0] ofs);
        rop_hit = (addr == ofs);
    endfunction : rop_hit

endpackage : rop_pkg

/* File: hw/rop_wdog.sv */
`timescale 1ns/1ps
module rop_wdog #(
    parameter int TIMEOUT = rop_pkg::WDOG_TIMEOUT_CLOCKS
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        restart_i,
    input  wire logic        feed_i,
    output logic             expire_o,
    output logic [31:0]      count_o
);

    localparam logic [31:0] LAST = 32'(TIMEOUT - 1);

    logic [31:0] cnt_r;
    logic        expire_r;

    // Counts from every reset onward; no disable exists
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt_r <= 32'h0;
        end else if (restart_i || feed_i || cnt_r == LAST) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            expire_r <= 1'b0;
        end else begin
            expire_r <= !restart_i && !feed_i && cnt_r == LAST;
        end
    end

    assign expire_o = expire_r;
    assign count_o  = cnt_r;

endmodule : rop_wdog

/* File: hw/rop_reset_out.sv */
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
// Operation
// - The external reset input resets the whole block when asserted.
// - With the function enabled, any internal reset drives the shared pin low, except one that arrives in the last cycle of a running pulse.
// - An external reset never starts a pulse on the shared pin.
// - Each pulse holds the pin low for exactly 256 clock cycles, then releases it.
// - At power-up the pin may be low for up to 258 clocks; here it stays high.
// - The watchdog comes out of every reset enabled and counting.
// - Watchdog expiry causes an internal reset, and a pulse if enabled.
// - The pin is shared with the timer and acts as reset indicator when selected or while a pulse runs.
// - The pulse does not mirror the reset input, so the pin may be wired back to it.
// - Bit 7 of the reset cause register enables the function, 1 on and 0 off.
// - The reset cause register records the last cause: bit 0 external, 1 command, 2 watchdog.
module rop_reset_out #(
    parameter int WDOG_TIMEOUT = rop_pkg::WDOG_TIMEOUT_CLOCKS
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        reset_instr_i,
    input  wire logic        timer_out_i,
    input  wire logic        timer_oe_i,
    input  wire logic        shared_port_reset_pin_i,
    output logic             timer_in_o,
    output logic             shared_port_reset_pin_o,
    output logic             shared_port_reset_pin_oe_o,
    output logic             chip_reset_o,
    output logic             irq_o
);

    rop_pkg::rop_state_t    state_r;
    logic [7:0]             pulse_cnt_r;
    logic                   reset_indicator_enable_r;
    logic [2:0]             cause_r;
    logic                   pin_mux_r;
    logic [2:0]             irq_stat_r;
    logic [2:0]             irq_mask_r;
    logic                   pready_r;
    logic                   pslverr_r;
    logic [31:0]            prdata_r;
    logic                   pin_out_r;
    logic                   pin_oe_r;
    logic                   timer_in_r;
    logic                   chip_reset_r;
    logic                   irq_r;
    logic                   wd_expire;
    logic [31:0]            wd_count;
    logic                   feed;
    logic                   internal_reset;
    logic                   start_pulse;
    logic                   pulse_done;
    logic                   access;
    logic                   wr;
    logic                   rd;
    logic                   mapped;
    logic [2:0]             irq_set;
    logic [2:0]             irq_clr;
    logic [31:0]            rdata_nxt;
    logic [2:0]             irq_stat_nxt;
    logic                   in_pulse;
    logic                   pin_drive;
    logic                   wr_cause;
    logic                   wr_feed;
    logic                   wr_stat;
    logic                   wr_mask;
    logic                   wr_mux;

    // APB access phase, answered one cycle after it opens
    assign access = psel_i && penable_i && !pready_r;
    assign wr     = psel_i && penable_i && pready_r && pwrite_i;
    assign rd     = access && !pwrite_i;

    // One strobe per register, high only at the edge that completes a write
    assign wr_cause = wr && rop_pkg::rop_hit(paddr_i, rop_pkg::CAUSE_OFS);
    assign wr_feed  = wr && rop_pkg::rop_hit(paddr_i, rop_pkg::FEED_OFS);
    assign wr_stat  = wr && rop_pkg::rop_hit(paddr_i, rop_pkg::IRQ_STAT_OFS);
    assign wr_mask  = wr && rop_pkg::rop_hit(paddr_i, rop_pkg::IRQ_MASK_OFS);
    assign wr_mux   = wr && rop_pkg::rop_hit(paddr_i, rop_pkg::PIN_MUX_OFS);

    assign feed = wr_feed
               && pwdata_i[7:0] == rop_pkg::FEED_KEY;

    // Internal resets: reset command or watchdog expiry only
    assign internal_reset = reset_instr_i || wd_expire;
    // The reset input is not part of this term, so it never reaches the pin
    assign start_pulse    = internal_reset && reset_indicator_enable_r
                         && state_r == rop_pkg::ROP_IDLE;
    assign in_pulse       = state_r == rop_pkg::ROP_PULSE;
    assign pulse_done     = in_pulse && pulse_cnt_r == 8'h00;
    assign pin_drive      = pin_mux_r || start_pulse || in_pulse;

    rop_wdog #(
        .TIMEOUT   (WDOG_TIMEOUT)
    ) u_wdog (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .restart_i (chip_reset_r),
        .feed_i    (feed),
        .expire_o  (wd_expire),
        .count_o   (wd_count)
    );

    // Pulse sequencer
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_r <= rop_pkg::ROP_IDLE;
        end else begin
            case (state_r)
                rop_pkg::ROP_IDLE: begin
                    if (start_pulse) begin
                        state_r <= rop_pkg::ROP_PULSE;
                    end
                end
                rop_pkg::ROP_PULSE: begin
                    if (pulse_cnt_r == 8'h00) begin
                        state_r <= rop_pkg::ROP_IDLE;
                    end
                end
                default: begin
                    state_r <= rop_pkg::ROP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pulse_cnt_r <= 8'h00;
        end else if (start_pulse) begin
            pulse_cnt_r <= rop_pkg::PULSE_LAST;
        end else if (in_pulse && pulse_cnt_r != 8'h00) begin
            pulse_cnt_r <= pulse_cnt_r - 8'h01;
        end
    end

    // Enable survives internal resets so a watchdog pulse can follow
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reset_indicator_enable_r <= rop_pkg::ENABLE_RST;
        end else if (wr_cause) begin
            reset_indicator_enable_r <= pwdata_i[rop_pkg::ENABLE_BIT];
        end
    end

    // Last cause; a tied-back pin arrives as an external reset and overwrites it
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cause_r <= rop_pkg::CAUSE_EXT;
        end else if (wd_expire) begin
            cause_r <= rop_pkg::CAUSE_WD;
        end else if (reset_instr_i) begin
            cause_r <= rop_pkg::CAUSE_CMD;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_mux_r <= rop_pkg::PIN_MUX_RST;
        end else if (wr_mux) begin
            pin_mux_r <= pwdata_i[rop_pkg::PIN_MUX_BIT];
        end
    end

    // Sticky interrupt flags, set wins over a write-one clear
    always_comb begin
        irq_set                        = 3'h0;
        irq_set[rop_pkg::IRQ_WD_BIT]   = wd_expire;
        irq_set[rop_pkg::IRQ_CMD_BIT]  = reset_instr_i;
        irq_set[rop_pkg::IRQ_DONE_BIT] = pulse_done;
        irq_clr = 3'h0;
        if (wr_stat) begin
            irq_clr = pwdata_i[2:0];
        end
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            irq_stat_r <= 3'h0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // Mask bits gate the level output only, never the sticky flags
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            irq_mask_r <= rop_pkg::IRQ_MASK_RST;
        end else if (wr_mask) begin
            irq_mask_r <= pwdata_i[2:0];
        end
    end

    // Level output follows the next status so it rises with the flag
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // Read mux and address decode
    always_comb begin
        rdata_nxt = 32'h0;
        mapped    = 1'b1;
        case (paddr_i)
            rop_pkg::CAUSE_OFS: begin
                rdata_nxt[rop_pkg::ENABLE_BIT] = reset_indicator_enable_r;
                rdata_nxt[2:0]                 = cause_r;
            end
            rop_pkg::FEED_OFS: begin
                rdata_nxt = wd_count;
            end
            rop_pkg::IRQ_STAT_OFS: begin
                rdata_nxt[2:0] = irq_stat_r;
            end
            rop_pkg::IRQ_MASK_OFS: begin
                rdata_nxt[2:0] = irq_mask_r;
            end
            rop_pkg::PIN_MUX_OFS: begin
                rdata_nxt[rop_pkg::PIN_MUX_BIT] = pin_mux_r;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Exactly one wait state; unmapped offsets answer with an error
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= access;
            pslverr_r <= access && !mapped;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            prdata_r <= 32'h0;
        end else if (rd) begin
            prdata_r <= rdata_nxt;
        end else if (access) begin
            prdata_r <= 32'h0;
        end
    end

    // Shared pin: high from reset, low during an active pulse, else follows the timer output when deselected
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_out_r <= 1'b1;
        end else if (pin_drive) begin
            pin_out_r <= !(start_pulse || (in_pulse && !pulse_done));
        end else begin
            pin_out_r <= timer_out_i;
        end
    end

    // Timer owns the enable only while the reset function is idle and deselected
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_oe_r <= 1'b0;
        end else if (pin_drive) begin
            pin_oe_r <= 1'b1;
        end else begin
            pin_oe_r <= timer_oe_i;
        end
    end

    // Timer input reads the pin level back in either mode
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            timer_in_r <= 1'b0;
        end else begin
            timer_in_r <= shared_port_reset_pin_i;
        end
    end

    // One-cycle internal reset; it also restarts the watchdog
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            chip_reset_r <= 1'b0;
        end else begin
            chip_reset_r <= internal_reset;
        end
    end

    assign prdata_o                   = prdata_r;
    assign pready_o                   = pready_r;
    assign pslverr_o                  = pslverr_r;
    assign timer_in_o                 = timer_in_r;
    assign shared_port_reset_pin_o    = pin_out_r;
    assign shared_port_reset_pin_oe_o = pin_oe_r;
    assign chip_reset_o               = chip_reset_r;
    assign irq_o                      = irq_r;

endmodule : rop_reset_out

/* File: testbench/rop_reset_out_chk.sv */
`timescale 1ns/1ps
module rop_reset_out_chk (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic reset_instr_i,
    input wire logic shared_port_reset_pin_o,
    input wire logic shared_port_reset_pin_oe_o,
    input wire logic chip_reset_o
);
    logic [9:0] pcnt_r;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Counts cycles of an indicator pulse from its first low cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) pcnt_r <= 10'h000;
        else if (pcnt_r == 10'h000) pcnt_r <= {9'h000, chip_reset_o & !shared_port_reset_pin_o};
        else if (!shared_port_reset_pin_o) pcnt_r <= pcnt_r + 10'h001;
        else pcnt_r <= 10'h000;
    end
    property p_pulse_len;
        pcnt_r != 10'h000 && shared_port_reset_pin_o |-> pcnt_r == 10'h100;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse ended early");
    property p_pulse_end;
        pcnt_r == 10'h100 |-> shared_port_reset_pin_o;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");
    property p_oe;
        pcnt_r != 10'h000 |-> shared_port_reset_pin_oe_o;
    endproperty
    a_oe: assert property (p_oe) else $error("pin not driven in pulse");
    property p_instr;
        reset_instr_i && pcnt_r == 10'h000 |=> chip_reset_o;
    endproperty
    a_instr: assert property (p_instr) else $error("no internal reset");
    property p_chip_one;
        chip_reset_o |=> !chip_reset_o;
    endproperty
    a_chip_one: assert property (p_chip_one) else $error("reset pulse too long");
    property p_ext;
        $rose(rst_n_i) |-> (shared_port_reset_pin_o || !shared_port_reset_pin_oe_o) [*2];
    endproperty
    a_ext: assert property (p_ext) else $error("pin low after external reset");
    property p_ready_wait;
        psel_i && penable_i && !pready_o |=> pready_o;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready late");
    property p_err;
        pslverr_o |-> pready_o;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
endmodule : rop_reset_out_chk

/* File: testbench/rop_sys_dev.sv */
`timescale 1ns/1ps
module rop_sys_dev (
    input  wire logic clock_i,
    input  wire logic pin_i,
    input  wire logic pin_oe_i,
    output logic      line_o,
    output int        pulses_o,
    output int        last_low_o
);
    int run;
    // Pull-up holds the line high when undriven
    assign line_o = pin_oe_i ? pin_i : 1'b1;
    always @(posedge clock_i) begin
        if (!line_o) run <= run + 1;
        else if (run != 0) begin
            pulses_o <= pulses_o + 1;
            last_low_o <= run;
            run <= 0;
        end
    end
endmodule : rop_sys_dev

/* File: testbench/rop_reset_out_tb.sv */
`timescale 1ns/1ps
module rop_reset_out_tb;
    logic clk, rst_n, psel, pen, pwr, rinst, tout, toe, rnd_en, pready, perr;
    logic timer_in, pin, pin_oe, chip_rst, irq, line, re;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv, v1;
    int bad_count, total_checks, seed, cyc, n, pulses, last_low, cause_m, en_m, stat_m;
    rop_reset_out #(.WDOG_TIMEOUT(2000)) u_dut (.clock_i(clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(perr), .reset_instr_i(rinst), .timer_out_i(tout),
        .timer_oe_i(toe), .shared_port_reset_pin_i(line), .timer_in_o(timer_in),
        .shared_port_reset_pin_o(pin), .shared_port_reset_pin_oe_o(pin_oe),
        .chip_reset_o(chip_rst), .irq_o(irq));
    rop_sys_dev u_dev (.clock_i(clk), .pin_i(pin), .pin_oe_i(pin_oe), .line_o(line),
        .pulses_o(pulses), .last_low_o(last_low));
    task summarize;
        if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        pen <= 1'b0;
        @(posedge clk) pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rv = prdata;
        re = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task rd(input logic [7:0] a, input int e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, 32'(e), rv);
    endtask : rd
    task fire;
        rinst <= 1'b1;
        @(posedge clk) rinst <= 1'b0;
        cause_m = 2;
        stat_m |= 2;
    endtask : fire
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        tout <= 1'($random(seed));
        toe <= rnd_en & 1'($random(seed));
        cyc++;
        if (cyc == 10000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        seed = 45774;
        {rst_n, psel, pen, pwr, rinst, rnd_en, paddr, pwdata} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        cause_m = 1;
        en_m = 0;
        stat_m = 0;
        rd(rop_pkg::CAUSE_OFS, 1, "cause");
        rd(rop_pkg::IRQ_MASK_OFS, 0, "mask");
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", 1, {31'h0, re});
        chk("line_idle", 1, {31'h0, line});
        chk("timer_in_idle", 1, {31'h0, timer_in});
        apb(1'b1, rop_pkg::PIN_MUX_OFS, 32'h1);
        apb(1'b1, rop_pkg::IRQ_MASK_OFS, 32'h5);
        rnd_en <= 1'b1;
        n = pulses;
        fire();
        repeat (300) @(posedge clk);
        chk("pulses_disabled", n, pulses);
        rd(rop_pkg::CAUSE_OFS, cause_m, "cause");
        chk("irq_masked", 0, {31'h0, irq});
        apb(1'b1, rop_pkg::IRQ_MASK_OFS, 32'h7);
        repeat (2) @(posedge clk);
        chk("irq_set", 1, {31'h0, irq});
        rd(rop_pkg::IRQ_STAT_OFS, stat_m, "status");
        apb(1'b1, rop_pkg::IRQ_STAT_OFS, 32'h2);
        stat_m = 0;
        repeat (2) @(posedge clk);
        chk("irq_clear", 0, {31'h0, irq});
        apb(1'b1, rop_pkg::FEED_OFS, {24'($random(seed)), rop_pkg::FEED_KEY});
        apb(1'b1, rop_pkg::CAUSE_OFS, 32'h80);
        en_m = 128;
        n = pulses;
        fire();
        repeat (10) @(posedge clk);
        chk("timer_in_pulse", 0, {31'h0, timer_in});
        fire();
        while (pulses == n) @(posedge clk);
        chk("pulse_len", 256, last_low);
        repeat (50) @(posedge clk);
        chk("pulse_count", n + 1, pulses);
        stat_m |= 4;
        rd(rop_pkg::IRQ_STAT_OFS, stat_m, "status");
        rd(rop_pkg::CAUSE_OFS, en_m + cause_m, "cause");
        apb(1'b1, rop_pkg::IRQ_STAT_OFS, 32'h7);
        n = pulses;
        while (pulses == n) @(posedge clk);
        chk("wd_pulse_len", 256, last_low);
        rd(rop_pkg::CAUSE_OFS, en_m + 4, "cause");
        rd(rop_pkg::IRQ_STAT_OFS, 5, "status");
        rnd_en <= 1'b0;
        n = pulses;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk("pulses_ext", n, pulses);
        rd(rop_pkg::CAUSE_OFS, 1, "cause");
        apb(1'b0, rop_pkg::FEED_OFS, 32'h0);
        v1 = rv;
        apb(1'b0, rop_pkg::FEED_OFS, 32'h0);
        chk("wd_running", 1, 32'(rv > v1));
        rnd_en <= 1'b1;
        repeat (20) begin
            v1 = {30'h0, toe, tout};
            @(posedge clk);
            chk("line_timer", {31'h0, (v1[1] ? v1[0] : 1'b1)}, {31'h0, line});
        end
        summarize();
    end
endmodule : rop_reset_out_tb
bind rop_reset_out rop_reset_out_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .reset_instr_i(reset_instr_i), .shared_port_reset_pin_o(shared_port_reset_pin_o),
    .shared_port_reset_pin_oe_o(shared_port_reset_pin_oe_o), .chip_reset_o(chip_reset_o));
